// [rfc_regs.v]
`timescale 1ns/1ps
`include "rfc_map.vh"

module rfc_regs #(
  parameter ADDR_W = 12
) (
  input  wire              pclk,
  input  wire              presetn,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [ADDR_W-1:0] paddr,
  input  wire [31:0]       pwdata,
  input  wire [3:0]        pstrb,
  output reg  [31:0]       prdata,
  output reg               pready,
  output reg               pslverr,
  input  wire              clkgen_override,
  input  wire              hw_clkgen_powerdown,
  output wire [2:0]        tx_clkmode_during_overshoot_guard,
  output wire              driver2_invert_reader,
  output wire              driver2_invert_card,
  output wire              driver1_invert_reader,
  output wire              driver1_invert_card,
  output wire [2:0]        reader_tx_clock_mode,
  output reg               carrier_clockgen_powerdown,
  output wire [3:0]        reader_cw_power_level,
  output wire [11:0]       amp_internal_use,
  output wire              output_voltage_style_select,
  output wire [1:0]        reader_cw_amplitude,
  output wire [1:0]        card_cw_amplitude,
  output wire [4:0]        residual_carrier,
  output wire              reader_force_max_output,
  output wire              card_force_max_output,
  output wire              transmitter_powerdown,
  output wire [14:0]       rx_internal_use,
  output wire [1:0]        rx_highpass_corner,
  output wire [1:0]        rx_baseband_gain
);

  reg  [31:0] clk_q;
  reg  [31:0] amp_q;
  reg  [31:0] rx_q;
  reg  [31:0] rdata_d;
  reg         hit_d;
  wire        setup_ph;
  wire        wr_done;
  wire [31:0] lane_mask;

  // byte enables widened to a bit mask
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_lane
      assign lane_mask[8*g+7:8*g] = {8{pstrb[g]}};
    end
  endgenerate

  function is_addr;
    input [ADDR_W-1:0] a;
    input [11:0]       a_ref;
    begin
      is_addr = (a == a_ref[ADDR_W-1:0]);
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] wdat;
    input [31:0] bmask;
    input [31:0] wmask;
    reg   [31:0] m;
    begin
      m = bmask & wmask;
      merge = (old & ~m) | (wdat & m);
    end
  endfunction

  assign setup_ph = psel & ~penable;
  // write lands only at the completing access edge
  assign wr_done  = psel & penable & pready & pwrite & ~pslverr;

  always @* begin
    rdata_d = 32'h0000_0000;
    hit_d   = 1'b1;
    if (is_addr(paddr, `RFC_ADDR_CLK)) begin
      rdata_d = clk_q & `RFC_CLK_WMASK;
    end else if (is_addr(paddr, `RFC_ADDR_AMP)) begin
      rdata_d = amp_q & `RFC_AMP_WMASK;
    end else if (is_addr(paddr, `RFC_ADDR_RX)) begin
      rdata_d = rx_q & (`RFC_RX_WMASK | `RFC_RX_FIELD_MASK);
    end else begin
      hit_d   = 1'b0;
    end
  end

  // answer in the first access cycle: zero wait states
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup_ph;
      pslverr <= setup_ph & ~hit_d;
      if (setup_ph && !pwrite) begin
        prdata <= rdata_d;
      end else if (!psel) begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_q <= `RFC_CLK_RESET;
      amp_q <= `RFC_AMP_RESET;
      rx_q  <= `RFC_RX_RESET;
    end else if (wr_done) begin
      if (is_addr(paddr, `RFC_ADDR_CLK)) begin
        clk_q <= merge(clk_q, pwdata, lane_mask, `RFC_CLK_WMASK);
      end
      if (is_addr(paddr, `RFC_ADDR_AMP)) begin
        amp_q <= merge(amp_q, pwdata, lane_mask, `RFC_AMP_WMASK);
      end
      if (is_addr(paddr, `RFC_ADDR_RX)) begin
        // internal-use bits are plain storage alongside the fields
        rx_q <= merge(rx_q, pwdata, lane_mask,
                      `RFC_RX_WMASK | `RFC_RX_FIELD_MASK);
      end
    end
  end

  // software bit only counts while overridden; otherwise hardware owns it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      carrier_clockgen_powerdown <= 1'b1;
    end else begin
      carrier_clockgen_powerdown <= clkgen_override ? clk_q[`RFC_CLK_GEN_PD]
                                                    : hw_clkgen_powerdown;
    end
  end

  assign tx_clkmode_during_overshoot_guard = clk_q[`RFC_CLK_GUARD_MODE];
  assign driver2_invert_reader       = clk_q[`RFC_CLK_D2_INV_RD];
  assign driver2_invert_card         = clk_q[`RFC_CLK_D2_INV_CD];
  assign driver1_invert_reader       = clk_q[`RFC_CLK_D1_INV_RD];
  assign driver1_invert_card         = clk_q[`RFC_CLK_D1_INV_CD];
  assign reader_tx_clock_mode        = clk_q[`RFC_CLK_RD_MODE];
  assign reader_cw_power_level       = amp_q[`RFC_AMP_RD_LEVEL];
  assign amp_internal_use            = amp_q[`RFC_AMP_INTERNAL];
  assign output_voltage_style_select = amp_q[`RFC_AMP_STYLE];
  assign reader_cw_amplitude         = amp_q[`RFC_AMP_RD_CW];
  assign card_cw_amplitude           = amp_q[`RFC_AMP_CD_CW];
  assign residual_carrier            = amp_q[`RFC_AMP_RESIDUAL];
  assign reader_force_max_output     = amp_q[`RFC_AMP_RD_MAX];
  assign card_force_max_output       = amp_q[`RFC_AMP_CD_MAX];
  assign transmitter_powerdown       = amp_q[`RFC_AMP_TRANSMITTER_POWERDOWN];
  assign rx_internal_use             = rx_q[`RFC_RX_INTERNAL];
  assign rx_highpass_corner          = rx_q[`RFC_RX_HIGHPASS_CORNER];
  assign rx_baseband_gain            = rx_q[`RFC_RX_GAIN];

endmodule // rfc_regs

// [rfc_map.vh]
`ifndef RFC_MAP_VH
`define RFC_MAP_VH

// register byte addresses
`define RFC_ADDR_CLK        12'h104
`define RFC_ADDR_AMP        12'h108
`define RFC_ADDR_RX         12'h110

// reset values
`define RFC_CLK_RESET       32'h0000_0083
`define RFC_AMP_RESET       32'h0000_0003
`define RFC_RX_RESET        32'h0003_D820

// writable bits; all others read zero
`define RFC_CLK_WMASK       32'h0000_07FF
`define RFC_AMP_WMASK       32'hFFFF_73FF
`define RFC_RX_WMASK        32'h0007_FFF0
`define RFC_RX_FIELD_MASK   32'h0000_000F

// clock word fields
`define RFC_CLK_GUARD_MODE  10:8
`define RFC_CLK_D2_INV_RD   7
`define RFC_CLK_D2_INV_CD   6
`define RFC_CLK_D1_INV_RD   5
`define RFC_CLK_D1_INV_CD   4
`define RFC_CLK_RD_MODE     3:1
`define RFC_CLK_GEN_PD      0

// amplitude word fields
`define RFC_AMP_RD_LEVEL    31:28
`define RFC_AMP_INTERNAL    27:16
`define RFC_AMP_STYLE       14
`define RFC_AMP_RD_CW       13:12
`define RFC_AMP_CD_CW       9:8
`define RFC_AMP_RESIDUAL    7:3
`define RFC_AMP_RD_MAX      2
`define RFC_AMP_CD_MAX      1
`define RFC_AMP_TRANSMITTER_POWERDOWN       0

// receive word fields
`define RFC_RX_INTERNAL     18:4
`define RFC_RX_HIGHPASS_CORNER         3:2
`define RFC_RX_GAIN         1:0

`endif

// [rfc_monitor.sv]
`timescale 1ns/1ps
`include "rfc_map.vh"
module rfc_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        clkgen_override,
  input wire logic        hw_clkgen_powerdown,
  input wire logic        carrier_clockgen_powerdown,
  input wire logic [14:0] rx_internal_use,
  input wire logic [1:0]  rx_highpass_corner,
  input wire logic [1:0]  rx_baseband_gain
);
  wire logic        map_ok = paddr == `RFC_ADDR_CLK || paddr == `RFC_ADDR_AMP ||
                             paddr == `RFC_ADDR_RX;
  wire logic [31:0] rx_w = {13'h0, rx_internal_use, rx_highpass_corner, rx_baseband_gain};
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_wr_rx; psel && penable && pready && pwrite && paddr == `RFC_ADDR_RX && pstrb == 4'hF;
  endsequence
  chk_ready_after_setup: assert property (s_setup |=> pready) else $error("no ready");
  chk_ready_one_cycle: assert property (pready |=> !pready) else $error("long ready");
  chk_err_unmapped: assert property (pready && !map_ok |-> pslverr) else $error("no err");
  chk_err_mapped: assert property (pready && map_ok |-> !pslverr) else $error("bad err");
  chk_rx_top_zero: assert property (pready && !pwrite && paddr == `RFC_ADDR_RX
    |-> prdata[31:19] == 13'h0) else $error("rx top set");
  chk_rx_fields: assert property (s_wr_rx |=> rx_w == ($past(pwdata) & 32'h0007_FFFF))
    else $error("rx fields");
  chk_rx_hold: assert property (!(psel && penable && pwrite) |=> $stable(rx_w))
    else $error("rx moved");
  chk_pd_follow: assert property (presetn && !clkgen_override
    |=> carrier_clockgen_powerdown == $past(hw_clkgen_powerdown)) else $error("pd");
endmodule // rfc_monitor
bind rfc_regs rfc_monitor rfc_monitor_i (.*);

// [rfc_hw_model.sv]
`timescale 1ns/1ps
module rfc_hw_model (
  input  wire logic pclk,
  input  wire logic presetn,
  output wire logic hw_pd
);
  logic [2:0] cnt_q;
  // hardware power-down request wanders on its own
  always @(posedge pclk or negedge presetn) if (!presetn) cnt_q <= 3'h0; else cnt_q <= cnt_q + 3'h1;
  assign hw_pd = cnt_q[2];
endmodule // rfc_hw_model

// [rf_frontend_tx_rx_config_regs_test.sv]
`timescale 1ns/1ps
`include "rfc_map.vh"
module rf_frontend_tx_rx_config_regs_test;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ovr = 0, err;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, rd;
  logic [3:0]  strb = 4'hF;
  wire  [31:0] prdata;
  wire         pready, pslverr, hw_pd, pd;
  int          error_cnt = 0, n_compared = 0;
  initial forever #25 pclk = ~pclk;
  rfc_hw_model rfc_hw_model_i (.pclk(pclk), .presetn(presetn), .hw_pd(hw_pd));
  rfc_regs rfc_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .clkgen_override(ovr), .hw_clkgen_powerdown(hw_pd),
    .carrier_clockgen_powerdown(pd), .tx_clkmode_during_overshoot_guard(),
    .driver2_invert_reader(), .driver2_invert_card(), .driver1_invert_reader(),
    .driver1_invert_card(), .reader_tx_clock_mode(), .reader_cw_power_level(),
    .amp_internal_use(), .output_voltage_style_select(), .reader_cw_amplitude(),
    .card_cw_amplitude(), .residual_carrier(), .reader_force_max_output(),
    .card_force_max_output(), .transmitter_powerdown(), .rx_internal_use(),
    .rx_highpass_corner(), .rx_baseband_gain());
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (n = 0; n < 8; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 8) begin
      error_cnt++;
      final_report;
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic t_reset;
    apb(0, `RFC_ADDR_CLK, 0);
    chk(rd, `RFC_CLK_RESET);
    apb(0, `RFC_ADDR_AMP, 0);
    chk(rd, `RFC_AMP_RESET);
    apb(0, `RFC_ADDR_RX, 0);
    chk(rd, `RFC_RX_RESET);
    $display("reset test done");
  endtask
  task automatic t_rw;
    logic [11:0] a[3] = '{`RFC_ADDR_CLK, `RFC_ADDR_AMP, `RFC_ADDR_RX};
    logic [31:0] m[3] = '{32'h0000_07FF, 32'hFFFF_73FF, 32'h0007_FFFF};
    logic [31:0] v[3] = '{32'hFFFF_FFFF, 32'hA5A5_5A5A, 32'h0};
    foreach (a[i]) foreach (v[j]) begin
      apb(1, a[i], v[j]);
      apb(0, a[i], 0);
      chk(rd, v[j] & m[i]);
    end
    $display("read write test done");
  endtask
  task automatic t_unmapped;
    apb(0, 12'h10C, 0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    $display("unmapped test done");
  endtask
  task automatic t_strobe;
    apb(1, `RFC_ADDR_AMP, 32'hFFFF_FFFF);
    strb <= 4'h5;
    apb(1, `RFC_ADDR_AMP, 32'h0);
    strb <= 4'hF;
    apb(0, `RFC_ADDR_AMP, 0);
    chk(rd, 32'hFF00_7300);
    $display("strobe test done");
  endtask
  task automatic t_rst2;
    apb(1, `RFC_ADDR_RX, 32'h0000_0005);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    t_reset;
    $display("second reset test done");
  endtask
  task automatic t_pd;
    ovr <= 1;
    apb(1, `RFC_ADDR_CLK, 0);
    repeat (2) @(negedge pclk);
    chk({31'h0, pd}, 32'h0);
    apb(1, `RFC_ADDR_CLK, 1);
    repeat (2) @(negedge pclk);
    chk({31'h0, pd}, 32'h1);
    ovr <= 0;
    repeat (8) @(posedge pclk);
    $display("power-down test done");
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    t_reset;
    t_rw;
    t_unmapped;
    t_pd;
    t_strobe;
    t_rst2;
    final_report;
  end
endmodule // rf_frontend_tx_rx_config_regs_test
